// File: rtl/dag_pkg.sv
// dag_pkg: constants, types and decode helpers for the data address generator.
// assumes a 12-bit linear data space, 8-bit data and an APB slave with 32-bit data.

package dag_pkg;

	localparam int DAG_AW = 12;
	localparam int DAG_DW = 8;
	localparam int DAG_NPTR = 3;

	// address formation
	localparam logic [7:0] DAG_LIT_MAX = 8'h5F;
	localparam logic [3:0] DAG_TOP_BANK = 4'hF;
	localparam logic [3:0] DAG_LOW_BANK = 4'h0;
	localparam logic [1:0] DAG_LIT_PTR = 2'h2;
	localparam logic [11:0] DAG_ONE = 12'h001;
	localparam logic [11:0] DAG_VOP_SPAN = 12'h006;
	localparam logic [7:0] DAG_ZERO_BYTE = 8'h00;

	// plain indirect operand address of each pointer; the rest of the group sits just below
	localparam logic [11:0] DAG_VOP_BASE0 = 12'hFEF;
	localparam logic [11:0] DAG_VOP_BASE1 = 12'hFE7;
	localparam logic [11:0] DAG_VOP_BASE2 = 12'hFDF;

	// apb register map
	localparam logic [7:0] DAG_REG_CTRL = 8'h00;
	localparam logic [7:0] DAG_REG_PTR0 = 8'h04;
	localparam logic [7:0] DAG_REG_PTR1 = 8'h08;
	localparam logic [7:0] DAG_REG_PTR2 = 8'h0C;
	localparam logic [7:0] DAG_REG_LAST = 8'h10;
	localparam int DAG_CTRL_EXT_BIT = 0;
	localparam int DAG_LAST_VIRT_BIT = 16;
	localparam int DAG_LAST_LIT_BIT = 17;
	localparam logic [31:0] DAG_RD_ZERO = 32'h0000_0000;

	// offset below the plain operand address gives the operand kind
	typedef enum logic [2:0] {
		DAG_K_PLAIN,
		DAG_K_POST_INC,
		DAG_K_POST_DEC,
		DAG_K_PRE_INC,
		DAG_K_W_OFF,
		DAG_K_BYTE_HI,
		DAG_K_BYTE_LO
	} dag_kind_t;

	typedef struct packed {
		logic hit;
		logic [1:0] idx;
		dag_kind_t kind;
	} dag_vop_t;

	// source of the data answered to the core
	typedef enum logic [1:0] {
		DAG_SRC_RAM,
		DAG_SRC_HELD,
		DAG_SRC_NONE
	} dag_src_t;

	// find which pointer group, if any, an address falls into
	function automatic dag_vop_t dag_decode(input logic [11:0] a);
		dag_vop_t res;
		logic [11:0] base;
		logic [11:0] off;
		res = '{hit: 1'b0, idx: 2'h0, kind: DAG_K_PLAIN};
		for (int i = 0; i < DAG_NPTR; i++) begin
			base = (i == 0) ? DAG_VOP_BASE0 : ((i == 1) ? DAG_VOP_BASE1 : DAG_VOP_BASE2);
			off = base - a;
			if (off <= DAG_VOP_SPAN) begin
				res.hit = 1'b1;
				res.idx = 2'(i);
				res.kind = dag_kind_t'(off[2:0]);
			end
		end
		return res;
	endfunction : dag_decode

	// true for the five operands that redirect through a pointer
	function automatic logic dag_is_virtual(input dag_vop_t v);
		return v.hit && (v.kind != DAG_K_BYTE_HI) && (v.kind != DAG_K_BYTE_LO);
	endfunction : dag_is_virtual

endpackage : dag_pkg

// File: rtl/dag_ptr_file.sv
// dag_ptr_file: the three 12-bit pointer pairs.
// assumes one write enable and value per pointer, already arbitrated by the caller.
`timescale 1ns/100ps
`default_nettype none

module dag_ptr_file
	import dag_pkg::*;
(
	input wire logic mclk, // core clock
	input wire logic rstn, // async reset, active low
	input wire logic [DAG_NPTR-1:0] wr_en, // per-pointer write enable
	input wire logic [DAG_NPTR-1:0][DAG_AW-1:0] wr_val, // per-pointer new value
	output logic [DAG_NPTR-1:0][DAG_AW-1:0] ptr // current pointer values
);

	logic [DAG_NPTR-1:0][DAG_AW-1:0] ptr_reg;
	logic [DAG_NPTR-1:0][DAG_AW-1:0] ptr_next;

	// next pointer values, 12 bits only so the high nibble cannot exist
	always_comb begin
		for (int i = 0; i < DAG_NPTR; i++) begin
			ptr_next[i] = wr_en[i] ? wr_val[i] : ptr_reg[i];
		end
	end

	// pointer storage
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ptr_reg <= '0;
		end else begin
			ptr_reg <= ptr_next;
		end
	end

	assign ptr = ptr_reg;

endmodule : dag_ptr_file

`default_nettype wire

// File: rtl/dag_top.sv
// dag_top: data address generator with pointer pairs, operand redirection and apb access.
// assumes the decoder raises core_req for one cycle per data access and waits for core_rsp;
// the data ram answers mem_rdata combinationally in the same cycle as mem_re.
// the apb slave inserts one wait state; unmapped offsets answer with pslverr.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none

module dag_top
	import dag_pkg::*;
(
	input wire logic mclk, // core clock, 100 MHz
	input wire logic rstn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic core_req, // decoder access request, one cycle
	input wire logic core_acc, // access select bit of the instruction
	input wire logic [7:0] core_file, // 8-bit file field
	input wire logic core_wr, // 1 write, 0 read
	input wire logic [DAG_DW-1:0] core_wdata, // data to write
	input wire logic [DAG_DW-1:0] core_w, // working register value
	input wire logic [3:0] core_bank, // bank select register value
	output logic core_rsp, // access done, one cycle
	output logic [DAG_DW-1:0] core_rdata, // read result
	output logic [DAG_AW-1:0] mem_addr, // data ram address
	output logic mem_re, // data ram read strobe
	output logic mem_we, // data ram write strobe
	output logic [DAG_DW-1:0] mem_wdata, // data ram write data
	input wire logic [DAG_DW-1:0] mem_rdata // data ram read data
);

	logic [DAG_NPTR-1:0][DAG_AW-1:0] ptr;
	logic [DAG_NPTR-1:0] ptr_wen;
	logic [DAG_NPTR-1:0][DAG_AW-1:0] ptr_wval;

	// apb state
	logic ext_reg, ext_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic [DAG_AW-1:0] last_reg, last_next;
	logic last_virt_reg, last_virt_next;
	logic last_lit_reg, last_lit_next;

	// core access pipeline state
	logic [DAG_AW-1:0] maddr_reg, maddr_next;
	logic mre_reg, mre_next;
	logic mwe_reg, mwe_next;
	logic [DAG_DW-1:0] mwdata_reg, mwdata_next;
	logic pend_reg, pend_next;
	dag_src_t src_reg, src_next;
	logic [DAG_DW-1:0] held_reg, held_next;
	logic rsp_reg, rsp_next;
	logic [DAG_DW-1:0] rdata_reg, rdata_next;

	// address formation results
	logic lit_mode;
	logic [DAG_AW-1:0] direct;
	dag_vop_t vop1, vop2;
	logic indirect;
	logic [DAG_AW-1:0] pval, tgt, step_val;
	logic step_en;
	logic apb_wr;
	logic apb_acc;
	logic virt_hit;
	logic [DAG_AW-1:0] w_ext;

	dag_ptr_file u_ptr (
		.mclk(mclk),
		.rstn(rstn),
		.wr_en(ptr_wen),
		.wr_val(ptr_wval),
		.ptr(ptr)
	);

	// access phase still waiting, and the completing edge of a write
	assign apb_acc = psel && penable && !pready_reg;
	assign apb_wr = psel && penable && pready_reg && pwrite;

	// direct address of the instruction, then redirection through a pointer
	always_comb begin
		lit_mode = ext_reg && !core_acc && (core_file <= DAG_LIT_MAX);
		if (core_acc) begin
			direct = {core_bank, core_file};
		end else if (lit_mode) begin
			direct = ptr[DAG_LIT_PTR] + {DAG_LOW_BANK, core_file};
		end else begin
			direct = {(core_file[7] ? DAG_TOP_BANK : DAG_LOW_BANK), core_file};
		end
		// a hit on a virtual operand address redirects through its pointer
		vop1 = dag_decode(direct);
		indirect = dag_is_virtual(vop1);
		pval = ptr[vop1.idx];
		// working register taken as a signed offset
		w_ext = {{(DAG_AW - DAG_DW){core_w[DAG_DW-1]}}, core_w};
		step_en = 1'b0;
		step_val = pval;
		tgt = direct;
		// step and target chosen per operand kind
		if (indirect) begin
			unique case (vop1.kind)
				DAG_K_POST_INC: begin
					tgt = pval;
					step_en = 1'b1;
					step_val = pval + DAG_ONE;
				end
				DAG_K_POST_DEC: begin
					tgt = pval;
					step_en = 1'b1;
					step_val = pval - DAG_ONE;
				end
				DAG_K_PRE_INC: begin
					tgt = pval + DAG_ONE;
					step_en = 1'b1;
					step_val = pval + DAG_ONE;
				end
				DAG_K_W_OFF: begin
					tgt = pval + w_ext;
				end
				default: begin
					tgt = pval;
				end
			endcase
		end
		vop2 = dag_decode(tgt);
		// a virtual operand reached through a pointer is never accessed
		virt_hit = indirect && dag_is_virtual(vop2);
	end

	// pointer writes: apb first, auto-modify over it, byte store over both
	always_comb begin
		for (int i = 0; i < DAG_NPTR; i++) begin
			ptr_wen[i] = 1'b0;
			ptr_wval[i] = ptr[i];
		end
		// apb store lands on the completing edge only
		if (apb_wr) begin
			unique case (paddr)
				DAG_REG_PTR0: begin
					ptr_wen[0] = 1'b1;
					ptr_wval[0] = pwdata[DAG_AW-1:0];
				end
				DAG_REG_PTR1: begin
					ptr_wen[1] = 1'b1;
					ptr_wval[1] = pwdata[DAG_AW-1:0];
				end
				DAG_REG_PTR2: begin
					ptr_wen[2] = 1'b1;
					ptr_wval[2] = pwdata[DAG_AW-1:0];
				end
				default: begin
				end
			endcase
		end
		// only the pointer moves; no status flag leaves this block
		if (core_req && step_en) begin
			ptr_wen[vop1.idx] = 1'b1;
			ptr_wval[vop1.idx] = step_val;
		end
		// a byte store keeps the written value, with no step applied
		if (core_req && core_wr && vop2.hit && !virt_hit) begin
			ptr_wen[vop2.idx] = 1'b1;
			if (vop2.kind == DAG_K_BYTE_HI) begin
				ptr_wval[vop2.idx] = {core_wdata[3:0], ptr[vop2.idx][7:0]};
			end else begin
				ptr_wval[vop2.idx] = {ptr[vop2.idx][11:8], core_wdata};
			end
		end
	end

	// core pipeline: cycle 1 drives the ram, cycle 2 answers the decoder
	always_comb begin
		maddr_next = maddr_reg;
		mre_next = 1'b0;
		mwe_next = 1'b0;
		mwdata_next = mwdata_reg;
		pend_next = core_req;
		src_next = src_reg;
		held_next = held_reg;
		last_next = last_reg;
		last_virt_next = last_virt_reg;
		last_lit_next = last_lit_reg;
		if (core_req) begin
			maddr_next = tgt;
			mwdata_next = core_wdata;
			last_next = tgt;
			last_virt_next = virt_hit;
			last_lit_next = lit_mode;
			// pointer bytes and virtual targets are answered here, ram stays idle
			if (virt_hit) begin
				src_next = DAG_SRC_NONE;
				held_next = DAG_ZERO_BYTE;
			end else if (vop2.hit) begin
				src_next = DAG_SRC_HELD;
				held_next = (vop2.kind == DAG_K_BYTE_HI) ? {4'h0, ptr[vop2.idx][11:8]} : ptr[vop2.idx][7:0];
			end else begin
				src_next = DAG_SRC_RAM;
				mre_next = !core_wr;
				mwe_next = core_wr;
			end
		end
		// second stage: ram data taken while the read strobe stands
		rsp_next = pend_reg;
		rdata_next = rdata_reg;
		if (pend_reg) begin
			rdata_next = (src_reg == DAG_SRC_RAM) ? mem_rdata : held_reg;
		end
	end

	// core pipeline registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			maddr_reg <= '0;
			mre_reg <= 1'b0;
			mwe_reg <= 1'b0;
			mwdata_reg <= '0;
			pend_reg <= 1'b0;
			src_reg <= DAG_SRC_NONE;
			held_reg <= '0;
			rsp_reg <= 1'b0;
			rdata_reg <= '0;
			last_reg <= '0;
			last_virt_reg <= 1'b0;
			last_lit_reg <= 1'b0;
		end else begin
			maddr_reg <= maddr_next;
			mre_reg <= mre_next;
			mwe_reg <= mwe_next;
			mwdata_reg <= mwdata_next;
			pend_reg <= pend_next;
			src_reg <= src_next;
			held_reg <= held_next;
			rsp_reg <= rsp_next;
			rdata_reg <= rdata_next;
			last_reg <= last_next;
			last_virt_reg <= last_virt_next;
			last_lit_reg <= last_lit_next;
		end
	end

	// apb slave: one wait state, read data and error registered with ready
	always_comb begin
		ext_next = ext_reg;
		pready_next = apb_acc;
		prdata_next = prdata_reg;
		pslverr_next = 1'b0;
		// read data built in the wait state, shown with pready
		if (apb_acc) begin
			prdata_next = DAG_RD_ZERO;
			unique case (paddr)
				DAG_REG_CTRL: prdata_next[DAG_CTRL_EXT_BIT] = ext_reg;
				DAG_REG_PTR0: prdata_next[DAG_AW-1:0] = ptr[0];
				DAG_REG_PTR1: prdata_next[DAG_AW-1:0] = ptr[1];
				DAG_REG_PTR2: prdata_next[DAG_AW-1:0] = ptr[2];
				DAG_REG_LAST: begin
					prdata_next[DAG_AW-1:0] = last_reg;
					prdata_next[DAG_LAST_VIRT_BIT] = last_virt_reg;
					prdata_next[DAG_LAST_LIT_BIT] = last_lit_reg;
				end
				default: pslverr_next = 1'b1;
			endcase
			// a write answers zero on the read data lines
			if (pwrite) begin
				prdata_next = DAG_RD_ZERO;
			end
		end
		// extended mode changes only by a software write
		if (apb_wr && (paddr == DAG_REG_CTRL)) begin
			ext_next = pwdata[DAG_CTRL_EXT_BIT];
		end
	end

	// apb registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ext_reg <= 1'b0;
			prdata_reg <= DAG_RD_ZERO;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			ext_reg <= ext_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// apb outputs
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	// core and ram outputs
	assign core_rsp = rsp_reg;
	assign core_rdata = rdata_reg;
	assign mem_addr = maddr_reg;
	assign mem_re = mre_reg;
	assign mem_we = mwe_reg;
	assign mem_wdata = mwdata_reg;

endmodule : dag_top

`default_nettype wire

// File: test/dag_ram_model.sv
// dag_ram_model: data ram on the memory side of the address generator.
// assumes combinational reads; off a read cycle the bus shows scrambled data.
`timescale 1ns/100ps
`default_nettype none

module dag_ram_model (
	input wire logic mclk, // clock
	input wire logic [11:0] mem_addr, // address
	input wire logic mem_re, // read strobe
	input wire logic mem_we, // write strobe
	input wire logic [7:0] mem_wdata, // write data
	output logic [7:0] mem_rdata // read data
);
	logic [7:0] ram [4096];

	// known fill pattern
	initial begin
		for (int i = 0; i < 4096; i++) begin
			ram[i] = 8'(i) ^ 8'hA5;
		end
	end
	// store on write strobe
	always @(posedge mclk) begin
		if (mem_we) begin
			ram[mem_addr] <= mem_wdata;
		end
	end
	// inverted data outside a read so stale values never match
	assign mem_rdata = mem_re ? ram[mem_addr] : ~ram[mem_addr];
endmodule : dag_ram_model
`default_nettype wire

// File: test/dag_top_asserts.sv
// dag_top_asserts: timing and address checks on the core side of dag_top.
// assumes only the top ports are visible; bound below.
`timescale 1ns/100ps
`default_nettype none

module dag_top_asserts (
	input wire logic mclk, // clock
	input wire logic rstn, // reset
	input wire logic core_req, // request
	input wire logic core_acc, // access select
	input wire logic [7:0] core_file, // file field
	input wire logic core_wr, // write
	input wire logic [7:0] core_wdata, // write data
	input wire logic [3:0] core_bank, // bank
	input wire logic core_rsp, // done
	input wire logic [11:0] mem_addr, // ram address
	input wire logic mem_re, // ram read
	input wire logic mem_we, // ram write
	input wire logic [7:0] mem_wdata // ram data
);
	// one clock domain
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	// request and its answer
	sequence s_req;
		core_req;
	endsequence
	sequence s_done;
		##2 core_rsp;
	endsequence
	sequence s_bank_req;
		core_req && core_acc && core_bank != 4'hF;
	endsequence

	property p_rsp;
		s_req |-> s_done;
	endproperty
	a_rsp: assert property (p_rsp) else $error("no answer two cycles after request");
	property p_rsp_cause;
		core_rsp |-> $past(core_req, 2);
	endproperty
	a_rsp_cause: assert property (p_rsp_cause) else $error("answer without request");
	property p_bank;
		s_bank_req |=> mem_addr == {$past(core_bank), $past(core_file)}
			&& mem_we == $past(core_wr) && mem_re == !$past(core_wr);
	endproperty
	a_bank: assert property (p_bank) else $error("banked address wrong");
	property p_low;
		core_req && !core_acc && core_file inside {[8'h60:8'h7F]} |=> mem_addr == {4'h0, $past(core_file)};
	endproperty
	a_low: assert property (p_low) else $error("low access bank address wrong");
	property p_high;
		core_req && !core_acc && core_file inside {[8'h80:8'hD8]} |=> mem_addr == {4'hF, $past(core_file)};
	endproperty
	a_high: assert property (p_high) else $error("top access bank address wrong");
	property p_strobe;
		mem_re || mem_we |-> $past(core_req);
	endproperty
	a_strobe: assert property (p_strobe) else $error("ram strobe without request");
	property p_excl;
		!(mem_re && mem_we);
	endproperty
	a_excl: assert property (p_excl) else $error("read and write strobes together");
	property p_wdata;
		mem_we |-> mem_wdata == $past(core_wdata) && $past(core_wr);
	endproperty
	a_wdata: assert property (p_wdata) else $error("ram write data wrong");
endmodule : dag_top_asserts

bind dag_top dag_top_asserts u_chk (.mclk, .rstn, .core_req, .core_acc, .core_file, .core_wr, .core_wdata,
	.core_bank, .core_rsp, .mem_addr, .mem_re, .mem_we, .mem_wdata);
`default_nettype wire

// File: test/test_data_address_generator.sv
// test_data_address_generator: directed scenarios for dag_top with a ram model.
// assumes an apb master here and the ram model on the memory side.
`timescale 1ns/100ps
`default_nettype none

module test_data_address_generator;
	logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic core_req = 1'b0, core_acc = 1'b0, core_wr = 1'b0, pready, pslverr, core_rsp, mem_re, mem_we, er;
	logic [7:0] paddr = 8'h00, core_file = 8'h00, core_wdata = 8'h00, core_w = 8'h00;
	logic [7:0] core_rdata, mem_wdata, mem_rdata;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] core_bank = 4'h0;
	logic [11:0] mem_addr;
	int n_mismatch = 0, tests_run = 0;

	dag_top u_dut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.core_req, .core_acc, .core_file, .core_wr, .core_wdata, .core_w, .core_bank, .core_rsp,
		.core_rdata, .mem_addr, .mem_re, .mem_we, .mem_wdata, .mem_rdata);
	dag_ram_model u_ram (.mclk, .mem_addr, .mem_re, .mem_we, .mem_wdata, .mem_rdata);

	// clock
	always #5 mclk = ~mclk;

	function automatic logic [7:0] pat(input logic [11:0] a);
		return a[7:0] ^ 8'hA5;
	endfunction : pat

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk

	// apb transfer, held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("pready", 32'h1, 32'(pready));
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rreg(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask : rreg

	// one core access: strobes one cycle after, answer two after
	task acc(input logic a, input logic [7:0] f, input logic w, input logic [7:0] d, input logic [7:0] wv,
		input logic [11:0] ea, input logic [1:0] es, input logic [7:0] ed);
		@(posedge mclk);
		core_req <= 1'b1;
		core_acc <= a;
		core_file <= f;
		core_wr <= w;
		core_wdata <= d;
		core_w <= wv;
		@(posedge mclk);
		core_req <= 1'b0;
		@(posedge mclk);
		chk("mem_addr", 32'(ea), 32'(mem_addr));
		chk("strobes", 32'(es), 32'({mem_re, mem_we}));
		@(posedge mclk);
		chk("core_rsp", 32'h1, 32'(core_rsp));
		if (!w) chk("core_rdata", 32'(ed), 32'(core_rdata));
	endtask : acc

	task rdm(input logic [7:0] f, input logic [7:0] wv, input logic [11:0] ea);
		acc(1'b0, f, 1'b0, 8'h00, wv, ea, 2'b10, pat(ea));
	endtask : rdm

	// reset values, width, unmapped
	task t_regs;
		rreg("ctrl", 8'h00, 32'h0);
		rreg("ptr0", 8'h04, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk("pslverr", 32'h1, 32'(er));
		apb(1'b1, 8'h04, 32'hFFFF_F0FF);
		rreg("ptr0", 8'h04, 32'h0FF);
	endtask : t_regs

	// auto-modify across the byte boundary
	task t_step;
		rdm(8'hEE, 8'h00, 12'h0FF);
		rreg("ptr0", 8'h04, 32'h100);
		rdm(8'hED, 8'h00, 12'h100);
		rreg("ptr0", 8'h04, 32'h0FF);
		apb(1'b1, 8'h08, 32'h2FF);
		rdm(8'hE4, 8'h00, 12'h300);
		rreg("ptr1", 8'h08, 32'h300);
	endtask : t_step

	// signed offset, wrap below zero
	task t_woff;
		apb(1'b1, 8'h08, 32'h005);
		rdm(8'hE3, 8'hF0, 12'hFF5);
		rdm(8'hE3, 8'h7F, 12'h084);
		rreg("ptr1", 8'h08, 32'h005);
	endtask : t_woff

	// plain write then read back, virtual target, self write
	task t_plain;
		apb(1'b1, 8'h0C, 32'h123);
		acc(1'b0, 8'hDF, 1'b1, 8'h77, 8'h00, 12'h123, 2'b01, 8'h00);
		acc(1'b0, 8'hDF, 1'b0, 8'h00, 8'h00, 12'h123, 2'b10, 8'h77);
		rreg("ptr2", 8'h0C, 32'h123);
		apb(1'b1, 8'h04, 32'hFE7);
		acc(1'b0, 8'hEF, 1'b0, 8'h00, 8'h00, 12'hFE7, 2'b00, 8'h00);
		rreg("last", 8'h10, 32'h0001_0FE7);
		acc(1'b0, 8'hEF, 1'b1, 8'h3C, 8'h00, 12'hFE7, 2'b00, 8'h00);
		rreg("ptr1", 8'h08, 32'h005);
		apb(1'b1, 8'h0C, 32'hFD9);
		acc(1'b0, 8'hDD, 1'b1, 8'h40, 8'h00, 12'hFD9, 2'b00, 8'h00);
		rreg("ptr2", 8'h0C, 32'hF40);
	endtask : t_plain

	// access bank mapping with extended set off and on
	task t_ext;
		logic [11:0] t;
		apb(1'b1, 8'h0C, 32'hFF0);
		@(posedge mclk);
		core_bank <= 4'h3;
		for (int x = 0; x < 2; x++) begin
			apb(1'b1, 8'h00, 32'(x));
			t = x ? 12'h04F : 12'h05F;
			rdm(8'h5F, 8'h00, t);
			rreg("last", 8'h10, x ? 32'h0002_004F : 32'h0000_005F);
			rdm(8'h60, 8'h00, 12'h060);
			rdm(8'h90, 8'h00, 12'hF90);
			acc(1'b1, 8'h10, 1'b0, 8'h00, 8'h00, 12'h310, 2'b10, pat(12'h310));
			rdm(8'hE7, 8'h00, 12'h005);
		end
	endtask : t_ext

	task results;
		if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results

	// main sequence
	initial begin
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		t_regs;
		t_step;
		t_woff;
		t_plain;
		t_ext;
		results;
	end

	// watchdog
	initial begin
		repeat (5000) @(posedge mclk);
		n_mismatch++;
		results;
	end
endmodule : test_data_address_generator
`default_nettype wire
